// ==== verilog/fcs_top.sv ====
// loop clock mode selector: registers, mode logic and clock gating
`timescale 1ns/100ps
`default_nettype none
`include "fcs_cfg.svh"
module fcs_top import fcs_pkg::*; #(
  parameter int SETTLE_TICKS = `FCS_SETTLE_TICKS,
  parameter int OSC_INIT_TICKS = `FCS_OSC_INIT_TICKS,
  parameter int RELOCK_TICKS = `FCS_RELOCK_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // source clock ticks from the analog side
  input wire logic int_ref_tick,
  input wire logic ext_ref_tick,
  input wire logic loop_tick,
  // chip state
  input wire logic stop_mode,
  input wire logic debug_mode_active,
  // clock outputs, one-cycle ticks; fixed_freq_valid is a level
  output logic main_clk_out,
  output logic debug_clk_out,
  output logic int_ref_clk_out,
  output logic ext_ref_clk_out,
  output logic fixed_freq_clk,
  output logic fixed_freq_valid,
  // loop and oscillator control
  output logic loop_enable,
  output logic loop_ref_tick,
  output logic [9:0] loop_multiplier,
  output logic loop_locking,
  output logic osc_enable,
  output logic [8:0] int_ref_trim
);
  generate
    if (OSC_INIT_TICKS < 1 || OSC_INIT_TICKS > 65535 ||
        RELOCK_TICKS < 1 || RELOCK_TICKS > 255) begin : g_bad
      $error("fcs_top: count parameter out of range");
    end
  endgenerate

  fcs_ctrl1_t ctrl1;
  fcs_ctrl2_t ctrl2;
  logic [7:0] coarse_trim;
  logic fine_trim;
  logic osc_ready_flag;
  fcs_aphase_t aph;
  logic rd_wait;
  logic [1:0] act_sel;
  logic sel_tick;

  // ---------------------------------------------------------------
  // bus slave: writes take no wait, reads one wait state
  // ---------------------------------------------------------------
  wire logic ap_take = hsel && hready && htrans[1];
  wire logic wr_now = aph.valid && aph.write;
  wire logic rd_now = aph.valid && !aph.write;
  wire logic hit_ctrl1 = aph.addr == `FCS_OFS_CTRL1;
  wire logic hit_ctrl2 = aph.addr == `FCS_OFS_CTRL2;
  wire logic hit_trim = aph.addr == `FCS_OFS_TRIM;
  wire logic hit_status = aph.addr == `FCS_OFS_STATUS;

  // address phase capture; the word offset keeps only byte address bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aph <= '0;
    end else if (hready) begin
      aph <= '{valid: ap_take, write: hwrite, addr: haddr[7:0]};
    end
  end

  // status word built from live state
  wire logic [1:0] clk_mode_status = act_sel;
  logic [7:0] status_word;
  always_comb begin
    status_word = 8'h00;
    status_word[`FCS_ST_MODE_HI:`FCS_ST_MODE_LO] = clk_mode_status;
    status_word[`FCS_ST_OSC_RDY] = osc_ready_flag;
    status_word[`FCS_ST_FINE_TRIM] = fine_trim;
  end

  // read selection, unmapped offsets read as zero
  wire logic [7:0] rd_mux = hit_ctrl1 ? ctrl1 :
                            hit_ctrl2 ? ctrl2 :
                            hit_trim ? coarse_trim :
                            hit_status ? status_word : 8'h00;

  // first read data cycle stalls while the word is registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_wait <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      rd_wait <= rd_now && !rd_wait;
      if (rd_now && !rd_wait) begin
        hrdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  assign hreadyout = !(rd_now && !rd_wait);
  assign hresp = 1'b0;

  // control registers; divider writes act on the very next edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl1 <= `FCS_CTRL1_RST;
      ctrl2 <= `FCS_CTRL2_RST;
    end else if (wr_now) begin
      if (hit_ctrl1) ctrl1 <= hwdata[7:0];
      if (hit_ctrl2) ctrl2 <= hwdata[7:0];
    end
  end

  // trim survives every reset, so this process has no reset branch
  always_ff @(posedge clk) begin
    if (wr_now && hit_trim) coarse_trim <= hwdata[7:0];
    if (wr_now && hit_status) begin
      fine_trim <= hwdata[`FCS_ST_FINE_TRIM];
    end
  end

  // larger code, longer period; fine trim is the least step below coarse
  assign int_ref_trim = {coarse_trim, fine_trim};

  // ---------------------------------------------------------------
  // reference path and loop control
  // ---------------------------------------------------------------
  // loop reference never comes from outside while internal is chosen
  wire logic ref_src_tick = ctrl1.int_ref_select ? int_ref_tick :
                                                   ext_ref_tick;
  logic [6:0] ref_cnt;
  wire logic [6:0] ref_mask = 7'((8'h01 << ctrl1.ref_divider) - 8'h01);
  wire logic div_ref_tick = ref_src_tick && ((ref_cnt & ref_mask) == ref_mask);

  // reference divider counts source ticks, 1 to 128
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_cnt <= 7'h00;
    end else if (ref_src_tick) begin
      ref_cnt <= ref_cnt + 7'h01;
    end
  end

  // low power only bites in bypass and only while debug is idle
  wire logic lp_bypass = ctrl2.low_power_sel && !debug_mode_active;
  wire logic engaged = act_sel == `FCS_SEL_LOOP;
  wire logic next_loop_en = !stop_mode && (engaged || !lp_bypass);

  // relock count restarts on each change of reference choice
  logic int_ref_select_prev;
  logic [7:0] relock_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_ref_select_prev <= 1'b1;
      relock_cnt <= 8'h00;
    end else begin
      int_ref_select_prev <= ctrl1.int_ref_select;
      if (int_ref_select_prev != ctrl1.int_ref_select) begin
        relock_cnt <= 8'(RELOCK_TICKS);
      end else if (div_ref_tick && relock_cnt != 8'h00) begin
        relock_cnt <= relock_cnt - 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // oscillator start-up and ready flag
  // ---------------------------------------------------------------
  wire logic ext_in_use = (act_sel == `FCS_SEL_EXT) ||
                          (engaged && !ctrl1.int_ref_select);
  wire logic osc_want = ctrl2.osc_request &&
                        (ctrl2.ext_ref_out_en || ext_in_use);
  logic ext_en_prev;
  logic [15:0] osc_cnt;
  wire logic osc_done = osc_want && ext_ref_tick &&
                        (osc_cnt == 16'(OSC_INIT_TICKS - 1));
  // clear only on the two enabling bits going away
  wire logic osc_clear = !ctrl2.osc_request ||
                         (ext_en_prev && !ctrl2.ext_ref_out_en);

  // start-up count runs on oscillator ticks while it is wanted
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_cnt <= 16'h0000;
      ext_en_prev <= 1'b0;
    end else begin
      ext_en_prev <= ctrl2.ext_ref_out_en;
      if (!osc_want || osc_ready_flag) begin
        osc_cnt <= 16'h0000;
      end else if (ext_ref_tick) begin
        osc_cnt <= osc_cnt + 16'h0001;
      end
    end
  end

  // a set in the clearing cycle wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_ready_flag <= 1'b0;
    end else if (osc_done) begin
      osc_ready_flag <= 1'b1;
    end else if (osc_clear) begin
      osc_ready_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // clock selection and bus divider
  // ---------------------------------------------------------------
  wire logic loop_run_tick = loop_tick && next_loop_en;

  fcs_clk_switch #(
    .SETTLE(SETTLE_TICKS)
  ) u_switch (
    .clk(clk),
    .resetn(resetn),
    .src_tick({ext_ref_tick, int_ref_tick, loop_run_tick}),
    .req_sel(ctrl1.clock_select),
    .act_sel(act_sel),
    .out_tick(sel_tick)
  );

  logic [2:0] bus_cnt;
  wire logic [2:0] bus_mask = 3'((4'h1 << ctrl2.bus_divider) - 4'h1);
  // mask is recomputed each cycle, no resync of the new ratio
  wire logic bus_tick = sel_tick &&
                        ((bus_cnt & bus_mask) == bus_mask);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_cnt <= 3'h0;
    end else if (sel_tick) begin
      bus_cnt <= bus_cnt + 3'h1;
    end
  end

  // fixed clock valid when main clock is at least four times it
  wire logic [2:0] ffe_floor = {1'b0, ctrl2.bus_divider} + `FCS_FFE_MARGIN;
  wire logic next_ffe = engaged ||
                        (ctrl1.ref_divider >= ffe_floor);

  // ---------------------------------------------------------------
  // registered outputs; clock ticks and loop gated in stop, reference clocks only without their stop enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      main_clk_out <= 1'b0;
      debug_clk_out <= 1'b0;
      int_ref_clk_out <= 1'b0;
      ext_ref_clk_out <= 1'b0;
      fixed_freq_clk <= 1'b0;
      fixed_freq_valid <= 1'b1;
      loop_enable <= 1'b1;
      loop_ref_tick <= 1'b0;
      loop_locking <= 1'b0;
      osc_enable <= 1'b0;
    end else begin
      main_clk_out <= bus_tick && !stop_mode;
      // debug clock exists only while the loop runs
      debug_clk_out <= loop_run_tick;
      int_ref_clk_out <= int_ref_tick && ctrl1.int_ref_out_en &&
        (!stop_mode || ctrl1.int_ref_stop_en);
      ext_ref_clk_out <= ext_ref_tick && ctrl2.ext_ref_out_en &&
        (!stop_mode || ctrl2.ext_ref_stop_en);
      fixed_freq_clk <= div_ref_tick && !stop_mode;
      fixed_freq_valid <= next_ffe;
      loop_enable <= next_loop_en;
      loop_ref_tick <= div_ref_tick && next_loop_en;
      loop_locking <= relock_cnt != 8'h00;
      osc_enable <= osc_want;
    end
  end

  // the loop is told its ratio; the analog side does the locking
  assign loop_multiplier = `FCS_LOOP_MULT;
endmodule : fcs_top
`default_nettype wire

// ==== include/fcs_cfg.svh ====
// constants of the loop clock mode selector: offsets, fields, resets, counts
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
// register byte offsets
`define FCS_OFS_CTRL1 8'h00
`define FCS_OFS_CTRL2 8'h04
`define FCS_OFS_TRIM 8'h08
`define FCS_OFS_STATUS 8'h0C
// status register field positions
`define FCS_ST_MODE_HI 3
`define FCS_ST_MODE_LO 2
`define FCS_ST_OSC_RDY 1
`define FCS_ST_FINE_TRIM 0
// reset values
`define FCS_CTRL1_RST 8'h04
`define FCS_CTRL2_RST 8'h40
// clock select codes
`define FCS_SEL_LOOP 2'h0
`define FCS_SEL_INT 2'h1
`define FCS_SEL_EXT 2'h2
`define FCS_SEL_RSVD 2'h3
// counts
`define FCS_SETTLE_TICKS 4
`define FCS_OSC_INIT_TICKS 4096
`define FCS_RELOCK_TICKS 4
`define FCS_LOOP_MULT 10'h200
`define FCS_FFE_MARGIN 3'h2
`endif

// ==== include/fcs_pkg.sv ====
// types of the loop clock mode selector
package fcs_pkg;
  // first control word
  typedef struct packed {
    logic [1:0] clock_select;
    logic [2:0] ref_divider;
    logic int_ref_select;
    logic int_ref_out_en;
    logic int_ref_stop_en;
  } fcs_ctrl1_t;
  // second control word
  typedef struct packed {
    logic [1:0] bus_divider;
    logic freq_range;
    logic high_gain;
    logic low_power_sel;
    logic osc_request;
    logic ext_ref_out_en;
    logic ext_ref_stop_en;
  } fcs_ctrl2_t;
  // latched bus address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } fcs_aphase_t;
  // clock switch states
  typedef enum logic {SW_STEADY, SW_SETTLE} fcs_sw_state_t;
endpackage : fcs_pkg

// ==== verilog/fcs_clk_switch.sv ====
// glitch-free switch between loop, internal and external clock ticks
`timescale 1ns/100ps
`default_nettype none
`include "fcs_cfg.svh"
module fcs_clk_switch import fcs_pkg::*; #(
  parameter int SETTLE = `FCS_SETTLE_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // candidate clock ticks, index is the select code
  input wire logic [2:0] src_tick,
  // requested and applied selection
  input wire logic [1:0] req_sel,
  output logic [1:0] act_sel,
  output logic out_tick
);
  generate
    if (SETTLE < 1 || SETTLE > 255) begin : g_bad
      $error("fcs_clk_switch: SETTLE out of range");
    end
  endgenerate

  fcs_sw_state_t state;
  logic [1:0] pend_sel;
  logic [7:0] settle_cnt;

  // reserved code is never taken up; the old clock keeps running
  wire logic new_req = (req_sel != pend_sel) && (req_sel != `FCS_SEL_RSVD);
  wire logic pend_tick = src_tick[pend_sel];
  wire logic settled = pend_tick && (settle_cnt == 8'(SETTLE - 1));

  // hand over only after whole cycles of the new clock were seen
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SW_STEADY;
      pend_sel <= `FCS_SEL_LOOP;
      act_sel <= `FCS_SEL_LOOP;
      settle_cnt <= 8'h00;
    end else begin
      case (state)
        SW_STEADY: begin
          if (new_req && req_sel != act_sel) begin
            pend_sel <= req_sel;
            settle_cnt <= 8'h00;
            state <= SW_SETTLE;
          end else if (new_req) begin
            pend_sel <= req_sel;
          end
        end
        SW_SETTLE: begin
          if (new_req) begin
            pend_sel <= req_sel;
            settle_cnt <= 8'h00;
            state <= (req_sel == act_sel) ? SW_STEADY : SW_SETTLE;
          end else if (settled) begin
            act_sel <= pend_sel;
            state <= SW_STEADY;
          end else if (pend_tick) begin
            settle_cnt <= settle_cnt + 8'h01;
          end
        end
        default: state <= SW_STEADY;
      endcase
    end
  end

  // ticks are atomic, so a change of act_sel never splits a pulse
  assign out_tick = (act_sel == `FCS_SEL_RSVD) ? 1'b0 : src_tick[act_sel];
endmodule : fcs_clk_switch
`default_nettype wire

// ==== test/fcs_top_sva.sv ====
// port checker for the loop clock mode selector
`timescale 1ns/100ps
`default_nettype none
module fcs_top_sva (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ticks and chip state
  input wire logic int_ref_tick,
  input wire logic ext_ref_tick,
  input wire logic loop_tick,
  input wire logic stop_mode,
  input wire logic debug_mode_active,
  // derived clocks and loop control
  input wire logic main_clk_out,
  input wire logic debug_clk_out,
  input wire logic int_ref_clk_out,
  input wire logic ext_ref_clk_out,
  input wire logic fixed_freq_clk,
  input wire logic loop_enable,
  input wire logic loop_ref_tick,
  input wire logic [9:0] loop_multiplier
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // stop silences all but the reference outputs
  chk_stop_quiet: assert property ($past(stop_mode) |->
    !main_clk_out && !debug_clk_out && !fixed_freq_clk)
    else $error("derived clock ran in stop");
  chk_stop_loop_off: assert property (
    stop_mode [*2] |-> !loop_enable) else $error("loop on in stop");
  // debug keeps the loop alive whatever the low power bit says
  chk_debug_loop_on: assert property (
    $past(debug_mode_active) && !$past(stop_mode) |-> loop_enable)
    else $error("loop off in debug");
  // each output pulse needs its source tick one cycle earlier
  chk_int_ref_src: assert property (
    int_ref_clk_out |-> $past(int_ref_tick)) else $error("stray int ref");
  chk_ext_ref_src: assert property (
    ext_ref_clk_out |-> $past(ext_ref_tick)) else $error("stray ext ref");
  chk_debug_src: assert property (
    debug_clk_out |-> $past(loop_tick) && loop_enable)
    else $error("debug clock without running loop");
  chk_main_src: assert property (
    main_clk_out |-> $past(int_ref_tick) || $past(ext_ref_tick)
    || $past(loop_tick)) else $error("main pulse without a tick");
  chk_fixed_src: assert property (
    fixed_freq_clk |-> $past(int_ref_tick) || $past(ext_ref_tick))
    else $error("fixed clock without reference tick");
  chk_loop_mult: assert property (
    loop_multiplier == 10'h200) else $error("loop multiplier wrong");
  // the loop only sees reference ticks while it is powered
  chk_ref_tick_gate: assert property (
    loop_ref_tick |-> loop_enable) else $error("ref tick to idle loop");
endmodule : fcs_top_sva
bind fcs_top fcs_top_sva u_sva (.clk(clk), .resetn(resetn),
  .int_ref_tick(int_ref_tick), .ext_ref_tick(ext_ref_tick),
  .loop_tick(loop_tick), .stop_mode(stop_mode),
  .debug_mode_active(debug_mode_active), .main_clk_out(main_clk_out),
  .debug_clk_out(debug_clk_out), .int_ref_clk_out(int_ref_clk_out),
  .ext_ref_clk_out(ext_ref_clk_out), .fixed_freq_clk(fixed_freq_clk),
  .loop_enable(loop_enable), .loop_ref_tick(loop_ref_tick),
  .loop_multiplier(loop_multiplier));
`default_nettype wire

// ==== test/fcs_top_tb_top.sv ====
// self-checking bench for the loop clock mode selector
`timescale 1ns/100ps
`default_nettype none
`include "fcs_cfg.svh"
module fcs_top_tb_top;
  wire hready;
  logic clk, resetn, hsel, hwrite, hresp, ext_run;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic int_ref_tick, ext_ref_tick, loop_tick, stop_mode, debug_mode_active;
  logic main_clk_out, debug_clk_out, int_ref_clk_out, ext_ref_clk_out;
  logic fixed_freq_valid, loop_enable, osc_enable, loop_locking;
  logic [8:0] int_ref_trim;
  int failures, checked, cyc;
  int n[4];
  int s[4];

  // unit under test, short oscillator start-up for simulation
  fcs_top #(.OSC_INIT_TICKS(8)) dut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .int_ref_tick(int_ref_tick), .ext_ref_tick(ext_ref_tick),
    .loop_tick(loop_tick), .stop_mode(stop_mode),
    .debug_mode_active(debug_mode_active), .main_clk_out(main_clk_out),
    .debug_clk_out(debug_clk_out), .int_ref_clk_out(int_ref_clk_out),
    .ext_ref_clk_out(ext_ref_clk_out), .fixed_freq_clk(),
    .fixed_freq_valid(fixed_freq_valid), .loop_enable(loop_enable),
    .loop_ref_tick(), .loop_multiplier(), .loop_locking(loop_locking),
    .osc_enable(osc_enable), .int_ref_trim(int_ref_trim));

  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ticks: internal every 8, external every 6, loop every 2 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    int_ref_tick <= (cyc % 8 == 0);
    ext_ref_tick <= ext_run && (cyc % 6 == 3);
    loop_tick <= (cyc % 2 == 1);
    n[0] <= n[0] + main_clk_out;
    n[1] <= n[1] + debug_clk_out;
    n[2] <= n[2] + int_ref_clk_out;
    n[3] <= n[3] + ext_ref_clk_out;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one ahb-lite single transfer, entered right after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(nm, rd, {24'h0, e});
  endtask : rc

  // snapshot pulse counters, then let k cycles pass
  task automatic span(input int k);
    s = n;
    repeat (k) @(posedge clk);
  endtask : span

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
  endtask : do_reset

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end

  // main sequence
  initial begin
    {hsel, hwrite, stop_mode, debug_mode_active, resetn} = 5'h00;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    ext_run = 1'b1;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rc("ctrl1", `FCS_OFS_CTRL1, 8'h04);
    rc("ctrl2", `FCS_OFS_CTRL2, 8'h40);
    check("valid", 32'(fixed_freq_valid), 32'h1);
    check("loop_en", 32'(loop_enable), 32'h1);
    wr(8'h10, 8'hFF);
    rc("unmapped", 8'h10, 8'h00);
    check("hresp", 32'(hresp), 32'h0);
    // trim survives a mid-run reset; status takes only fine trim
    wr(`FCS_OFS_TRIM, 8'hA5);
    wr(`FCS_OFS_STATUS, 8'hFF);
    rc("status", `FCS_OFS_STATUS, 8'h01);
    check("trim", 32'(int_ref_trim), 32'h14B);
    do_reset();
    rc("trim_rst", `FCS_OFS_TRIM, 8'hA5);
    rc("fine_trim_rst", `FCS_OFS_STATUS, 8'h01);
    // bypass internal: status lags the select write
    wr(`FCS_OFS_CTRL1, 8'h44);
    rc("lag", `FCS_OFS_STATUS, 8'h01);
    repeat (50) @(posedge clk);
    rc("fbi", `FCS_OFS_STATUS, 8'h05);
    // 32 internal ticks per window, divided by 1, 2, 4, 8
    for (int b = 0; b < 4; b++) begin
      wr(`FCS_OFS_CTRL2, 8'(b << 6));
      repeat (8) @(posedge clk);
      span(256);
      check("main", 32'(n[0] - s[0]), 32'(32 >> b));
    end
    // low power bypass, then debug keeps the loop
    wr(`FCS_OFS_CTRL2, 8'h08);
    repeat (4) @(posedge clk);
    check("lp_loop", 32'(loop_enable), 32'h0);
    span(64);
    check("lp_dbg", 32'(n[1] - s[1]), 32'h0);
    debug_mode_active <= 1'b1;
    repeat (4) @(posedge clk);
    check("bdm_loop", 32'(loop_enable), 32'h1);
    span(64);
    check("bdm_dbg", 32'(n[1] - s[1]), 32'd32);
    debug_mode_active <= 1'b0;
    // fixed clock valid threshold at each bus divider
    for (int b = 0; b < 4; b++) begin
      for (int r = b + 1; r <= b + 2; r++) begin
        wr(`FCS_OFS_CTRL2, 8'(b << 6));
        wr(`FCS_OFS_CTRL1, {2'h1, 3'(r), 3'h4});
        repeat (4) @(posedge clk);
        check("ffe", 32'(fixed_freq_valid), 32'(r >= b + 2));
      end
    end
    // oscillator ready sets after start-up, clears with the enable
    wr(`FCS_OFS_CTRL2, 8'h46);
    repeat (80) @(posedge clk);
    rc("osc_set", `FCS_OFS_STATUS, 8'h07);
    check("osc_en", 32'(osc_enable), 32'h1);
    span(60);
    check("ext_out", 32'(n[3] - s[3]), 32'd10);
    wr(`FCS_OFS_CTRL2, 8'h44);
    rc("osc_clr", `FCS_OFS_STATUS, 8'h05);
    wr(`FCS_OFS_CTRL2, 8'h40);
    // external bypass waits for a running external clock
    ext_run <= 1'b0;
    wr(`FCS_OFS_CTRL1, 8'h80);
    repeat (60) @(posedge clk);
    rc("no_ext", `FCS_OFS_STATUS, 8'h05);
    check("relock", 32'(loop_locking), 32'h1);
    ext_run <= 1'b1;
    repeat (60) @(posedge clk);
    rc("fbe", `FCS_OFS_STATUS, 8'h09);
    check("fbe_loop", 32'(loop_enable), 32'h1);
    check("locked", 32'(loop_locking), 32'h0);
    wr(`FCS_OFS_CTRL2, 8'h48);
    repeat (4) @(posedge clk);
    check("loop_bypass_external_lowpwr_loop", 32'(loop_enable), 32'h0);
    // loop engaged external: low power off first so the loop ticks
    wr(`FCS_OFS_CTRL2, 8'h40);
    wr(`FCS_OFS_CTRL1, 8'h00);
    repeat (20) @(posedge clk);
    rc("fee", `FCS_OFS_STATUS, 8'h01);
    check("fee_loop", 32'(loop_enable), 32'h1);
    // stop keeps the internal reference only with its stop enable
    wr(`FCS_OFS_CTRL1, 8'h47);
    stop_mode <= 1'b1;
    repeat (2) @(posedge clk);
    span(64);
    check("stop_irc", 32'(n[2] - s[2]), 32'd8);
    check("stop_main", 32'(n[0] - s[0]), 32'h0);
    wr(`FCS_OFS_CTRL1, 8'h46);
    // pulses launched before the write landed must leave the window
    repeat (2) @(posedge clk);
    span(64);
    check("stop_off", 32'(n[2] - s[2]), 32'h0);
    stop_mode <= 1'b0;
    print_verdict();
  end
endmodule : fcs_top_tb_top
`default_nettype wire
